/* tbt_pkg.sv */
// constants, register layout and helpers for the general-purpose timer bank
package tbt_pkg;

  // register map: one 16-byte block per timer, status word after the blocks
  localparam logic [3:0] CON_OFF = 4'h0;
  localparam logic [3:0] CNT_OFF = 4'h4;
  localparam logic [3:0] PER_OFF = 4'h8;
  localparam logic [7:0] STAT_ADDR = 8'h80;

  // control register field positions
  localparam int ON_BIT = 15;
  localparam int STOP_IN_IDLE_BIT = 13;
  localparam int GATE_BIT = 7;
  localparam int PS_LSB = 4;
  localparam int WIDE_BIT = 3;
  localparam int CS_BIT = 1;

  // writable bits of the control register, odd timers lack the wide bit
  localparam logic [15:0] CON_MASK_EVEN = 16'hA0FA;
  localparam logic [15:0] CON_MASK_ODD = 16'hA0F2;

  // values after reset
  localparam logic [15:0] CON_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hFFFF;
  localparam logic [7:0] PRE_RST = 8'h00;

  // terminal count of the prescaler for each select code
  function automatic logic [7:0] prescale_last(input logic [2:0] sel);
    case (sel)
      3'h0: prescale_last = 8'h00;
      3'h1: prescale_last = 8'h01;
      3'h2: prescale_last = 8'h03;
      3'h3: prescale_last = 8'h07;
      3'h4: prescale_last = 8'h0F;
      3'h5: prescale_last = 8'h1F;
      3'h6: prescale_last = 8'h3F;
      default: prescale_last = 8'hFF;
    endcase
  endfunction

  // register hit test for timer t at offset off
  function automatic logic reg_hit(input logic [7:0] addr, input int t, input logic [3:0] off);
    reg_hit = (addr[7] == 1'b0) && (addr[6:4] == t[2:0]) && (addr[3:0] == off);
  endfunction

endpackage

/* tbt_cfg_if.sv */
// effective configuration handed from the register file to one tick generator
`timescale 1ns/1ps
interface tbt_cfg_if;
  logic on;
  logic halt_idle;
  logic gate_en;
  logic clk_src;
  logic [2:0] prescale_select;
  modport ctrl (output on, halt_idle, gate_en, clk_src, prescale_select);
  modport unit (input on, halt_idle, gate_en, clk_src, prescale_select);
endinterface

/* tbt_tick.sv */
// prescaler and gating: turns a clock source into count ticks
`timescale 1ns/1ps
module tbt_tick
  import tbt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // configuration
  tbt_cfg_if.unit cfg,
  // pins and device state
  input wire logic ext_clk,
  input wire logic ext_gate,
  input wire logic dev_idle,
  // result
  output logic tick
);

  logic ext_prev_reg;
  logic [7:0] pre_reg;
  logic [7:0] pre_next;
  logic src_edge;
  logic gate_ok;
  logic run;
  logic at_last;

  assign src_edge = cfg.clk_src ? (ext_clk & ~ext_prev_reg) : 1'b1; // [R11]
  assign gate_ok = (cfg.gate_en && !cfg.clk_src) ? ext_gate : 1'b1; // [R4]
  assign run = cfg.on && !(cfg.halt_idle && dev_idle) && gate_ok; // [R1] [R2]
  // a smaller prescale picked mid-count ends the current cycle at once
  assign at_last = (pre_reg >= prescale_last(cfg.prescale_select)); // [R5]
  assign tick = run && src_edge && at_last;
  assign pre_next = !cfg.on ? PRE_RST :
                    (run && src_edge) ? (at_last ? PRE_RST : 8'(pre_reg + 8'h01)) : pre_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_reg <= 1'b0;
      pre_reg <= PRE_RST;
    end else if (ce) begin
      ext_prev_reg <= ext_clk;
      pre_reg <= pre_next;
    end
  end

endmodule

/* tbt_top.sv */
// bank of general-purpose 16-bit timers with pairwise 32-bit chaining
// Functional notes
// R1 - timer counts only while enable bit set
// R2 - stop-in-idle bit halts timer during idle
// R3 - external source: gate bit ignored, reads zero
// R4 - internal source plus gate bit: count while gated
// R5 - prescale codes 1,2,4,8,16,32,64,256
// R6 - wide bit chains even/odd into 32 bits
// R7 - chained pair governed by even control register
// R8 - software clears odd stop-idle for idle running
// R9 - wide bit exists only on even timers
// R10 - upper and unimplemented control bits read zero
// R11 - source bit picks peripheral clock or pin edges
// R12 - count, clear on period match, raise flag
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module tbt_top
  import tbt_pkg::*;
#(
  parameter int NUM_TIMERS = 8
)(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [31:0] RD_DATA,
  // device state and timer pins
  input wire logic DEV_IDLE,
  input wire logic [NUM_TIMERS-1:0] TMR_CLK_IN,
  input wire logic [NUM_TIMERS-1:0] TMR_GATE_IN,
  // period match flags
  output logic [NUM_TIMERS-1:0] MATCH_FLAGS
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] con_reg [NUM_TIMERS];
  logic [15:0] cnt_reg [NUM_TIMERS];
  logic [15:0] per_reg [NUM_TIMERS];
  logic [15:0] con_next [NUM_TIMERS];
  logic [15:0] cnt_next [NUM_TIMERS];
  logic [15:0] per_next [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] flag_reg;
  logic [NUM_TIMERS-1:0] flag_next;
  logic [NUM_TIMERS-1:0] match_set;
  logic [NUM_TIMERS-1:0] tick;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_next;
  logic stat_wr;
  logic stat_sel;
  logic [NUM_TIMERS-1:0] con_sel;
  logic [NUM_TIMERS-1:0] cnt_sel;
  logic [NUM_TIMERS-1:0] per_sel;
  logic [NUM_TIMERS-1:0] con_wr;
  logic [NUM_TIMERS-1:0] cnt_wr;
  logic [NUM_TIMERS-1:0] per_wr;
  logic [NUM_TIMERS/2-1:0] pair_wide;
  logic [15:0] con_view [NUM_TIMERS];

  ////////////////////////////////////////////////////////////////////////////
  // address decode: one select line per register of each timer
  assign stat_sel = (ADDR == STAT_ADDR);
  assign stat_wr = WR_EN && stat_sel;

  genvar d;
  generate
    for (d = 0; d < NUM_TIMERS; d++) begin : g_decode
      assign con_sel[d] = reg_hit(ADDR, d, CON_OFF);
      assign cnt_sel[d] = reg_hit(ADDR, d, CNT_OFF);
      assign per_sel[d] = reg_hit(ADDR, d, PER_OFF);
      assign con_wr[d] = WR_EN && con_sel[d];
      assign cnt_wr[d] = WR_EN && cnt_sel[d];
      assign per_wr[d] = WR_EN && per_sel[d];
      // gate bit is hidden, not cleared, while the pin clock is selected
      assign con_view[d] = {con_reg[d][15:GATE_BIT+1],
                            con_reg[d][GATE_BIT] & ~con_reg[d][CS_BIT],
                            con_reg[d][GATE_BIT-1:0]}; // [R3]
    end
  endgenerate

  // chaining is controlled by the even register of each pair only
  genvar q;
  generate
    for (q = 0; q < NUM_TIMERS / 2; q++) begin : g_pair
      assign pair_wide[q] = con_reg[2*q][WIDE_BIT]; // [R6] [R9]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // tick generators with effective configuration
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_unit
      localparam int E = (g / 2) * 2;
      tbt_cfg_if cfg ();
      wire wide = con_reg[E][WIDE_BIT];
      wire [15:0] src = (wide && (g % 2 == 1)) ? con_reg[E] : con_reg[g]; // [R7]
      assign cfg.on = src[ON_BIT];
      // a chained pair halts in idle if either half asks to stop
      assign cfg.halt_idle = src[STOP_IN_IDLE_BIT] | (wide & con_reg[E+1][STOP_IN_IDLE_BIT]); // [R8] [R2]
      assign cfg.gate_en = src[GATE_BIT];
      assign cfg.clk_src = src[CS_BIT];
      assign cfg.prescale_select = src[PS_LSB+2:PS_LSB];
      tbt_tick u_tick (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .cfg(cfg),
        .ext_clk(wide ? TMR_CLK_IN[E] : TMR_CLK_IN[g]),
        .ext_gate(wide ? TMR_GATE_IN[E] : TMR_GATE_IN[g]),
        .dev_idle(DEV_IDLE),
        .tick(tick[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // counters, period match and software writes
  always_comb begin
    logic [31:0] full;
    logic [31:0] full_per;
    full = 32'h0;
    full_per = 32'h0;
    match_set = '0;
    for (int p = 0; p < NUM_TIMERS / 2; p++) begin
      cnt_next[2*p] = cnt_reg[2*p];
      cnt_next[2*p+1] = cnt_reg[2*p+1];
      if (pair_wide[p]) begin // [R6]
        full = {cnt_reg[2*p+1], cnt_reg[2*p]};
        full_per = {per_reg[2*p+1], per_reg[2*p]};
        if (tick[2*p]) begin
          if (full == full_per) begin // [R12]
            full = 32'h0;
            match_set[2*p+1] = 1'b1;
          end else begin
            full = 32'(full + 32'h1);
          end
        end
        cnt_next[2*p] = full[15:0];
        cnt_next[2*p+1] = full[31:16];
      end else begin
        for (int k = 2 * p; k < 2 * p + 2; k++) begin
          if (tick[k]) begin
            if (cnt_reg[k] == per_reg[k]) begin // [R12]
              cnt_next[k] = CNT_RST;
              match_set[k] = 1'b1;
            end else begin
              cnt_next[k] = 16'(cnt_reg[k] + 16'h1);
            end
          end
        end
      end
    end
    for (int t = 0; t < NUM_TIMERS; t++) begin
      con_next[t] = con_reg[t];
      per_next[t] = per_reg[t];
      if (con_wr[t]) begin
        con_next[t] = WR_DATA[15:0] & ((t % 2 == 0) ? CON_MASK_EVEN : CON_MASK_ODD); // [R9]
      end
      // a software write to a count wins over a tick in the same cycle
      if (cnt_wr[t]) begin
        cnt_next[t] = WR_DATA[15:0];
      end
      if (per_wr[t]) begin
        per_next[t] = WR_DATA[15:0];
      end
    end
  end

  // write-one-to-clear, a new match in the same cycle wins
  assign flag_next = (flag_reg & ~(stat_wr ? WR_DATA[NUM_TIMERS-1:0] : '0)) | match_set;

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rd_next = 32'h0;
    if (stat_sel) begin
      rd_next[NUM_TIMERS-1:0] = flag_reg;
    end
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (con_sel[t]) begin
        rd_next[15:0] = con_view[t]; // [R10] [R3]
      end
      if (cnt_sel[t]) begin
        rd_next[15:0] = cnt_reg[t];
      end
      if (per_sel[t]) begin
        rd_next[15:0] = per_reg[t];
      end
    end
    // read data stand one cycle after the strobe and are zero otherwise
    if (!RD_EN) begin
      rd_next = 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // every register holds while the clock enable is low
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        con_reg[t] <= CON_RST;
        cnt_reg[t] <= CNT_RST;
        per_reg[t] <= PER_RST;
      end
      flag_reg <= '0;
      rd_data_reg <= 32'h0;
    end else if (CE) begin
      con_reg <= con_next;
      cnt_reg <= cnt_next;
      per_reg <= per_next;
      flag_reg <= flag_next;
      rd_data_reg <= rd_next;
    end
  end

  assign RD_DATA = rd_data_reg;
  assign MATCH_FLAGS = flag_reg;

endmodule

/* tbt_asserts.sv */
// port assertions for the timer bank
`timescale 1ns/1ps
module tbt_asserts #(parameter int NUM_TIMERS = 8)(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [31:0] RD_DATA,
  // flags
  input wire logic [NUM_TIMERS-1:0] MATCH_FLAGS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire ctl_rd = CE && RD_EN && !ADDR[7] && ADDR[3:0] == 4'h0;
  wire bad_rd = CE && RD_EN && (ADDR[7] ? ADDR != 8'h80 : ADDR[1:0] != 2'h0 || &ADDR[3:2]);
  wire st_wr = CE && WR_EN && ADDR == 8'h80;
  wire [NUM_TIMERS-1:0] clr = st_wr ? WR_DATA[NUM_TIMERS-1:0] : '0;
  ////////////////////////
  a_idle_zero: assert property ($past(CE) && !$past(RD_EN) |-> RD_DATA == 32'h0)
    else $error("read data outside a read");
  a_upper_zero: assert property (RD_DATA[31:16] == 16'h0)
    else $error("upper read bits set");
  a_ctl_unimpl: assert property ($past(ctl_rd) |-> (RD_DATA & 32'h5F05) == 32'h0)
    else $error("unimplemented control bit set");
  a_odd_no_wide: assert property ($past(ctl_rd && ADDR[4]) |-> !RD_DATA[3])
    else $error("odd timer shows wide bit");
  a_gate_hidden: assert property ($past(ctl_rd) && RD_DATA[1] |-> !RD_DATA[7])
    else $error("gate bit visible with pin source");
  a_unmapped_zero: assert property ($past(bad_rd) |-> RD_DATA == 32'h0)
    else $error("unmapped read not zero");
  a_flag_sticky: assert property ((~MATCH_FLAGS & $past(MATCH_FLAGS & ~clr)) == '0)
    else $error("flag fell without clear");
  a_ce_freeze: assert property (!$past(CE) |-> $stable(RD_DATA) && $stable(MATCH_FLAGS))
    else $error("state moved with enable low");
endmodule

/* testbench.sv */
// self-checking bench for the timer bank
`timescale 1ns/1ps
module testbench;
  logic CLK = 0, SYS_RST = 1, CE = 1, WR_EN = 0, RD_EN = 0, DEV_IDLE = 0, ext_run = 0;
  logic [7:0] ADDR = '0, TMR_CLK_IN = '0, TMR_GATE_IN = '0, MATCH_FLAGS;
  logic [31:0] WR_DATA = '0, RD_DATA;
  int err_count = 0, samples_checked = 0, cyc = 0;
  int ratio[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  tbt_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .DEV_IDLE(DEV_IDLE),
    .TMR_CLK_IN(TMR_CLK_IN), .TMR_GATE_IN(TMR_GATE_IN), .MATCH_FLAGS(MATCH_FLAGS));
  initial forever #2 CLK = ~CLK;
  ////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_EN <= 1'b1;
    @(posedge CLK);
    WR_EN <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge CLK);
    RD_EN <= 1'b0;
    #1 chk(RD_DATA, e);
  endtask
  // cycles between two period matches of timer i
  task automatic meas(input int i, input int p);
    int t0;
    wr(8'h80, 32'hFF);
    do @(negedge CLK); while (MATCH_FLAGS[i] !== 1'b1);
    t0 = cyc;
    wr(8'h80, 32'hFF);
    do @(negedge CLK); while (MATCH_FLAGS[i] !== 1'b1);
    chk(cyc - t0, p);
    @(posedge CLK);
  endtask
  // timeout and pin clock source
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    TMR_CLK_IN <= {7'h00, ext_run & ~TMR_CLK_IN[0]};
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  ////////////////////////
  initial begin
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    for (int t = 0; t < 8; t++) begin
      rd(8'(t * 16), 32'h0);
      rd(8'(t * 16 + 8), 32'hFFFF);
      wr(8'(t * 16), '1);
      rd(8'(t * 16), t[0] ? 32'hA072 : 32'hA07A);
      wr(8'(t * 16), 32'h0);
    end
    wr(8'h00, 32'h80);
    rd(8'h00, 32'h80);
    wr(8'h0C, 32'h1234);
    rd(8'h0C, 32'h0);
    rd(8'h90, 32'h0);
    $display("register test done");
    wr(8'h08, 32'h3);
    for (int s = 0; s < 8; s++) begin
      wr(8'h00, 32'h8000 | (s << 4));
      meas(0, 4 * ratio[s]);
    end
    $display("prescale test done");
    wr(8'h00, 32'h8080);
    wr(8'h80, 32'hFF);
    repeat (20) @(negedge CLK);
    chk(MATCH_FLAGS[0], 32'h0);
    @(posedge CLK);
    TMR_GATE_IN <= 8'h01;
    meas(0, 4);
    TMR_GATE_IN <= 8'h00;
    ext_run <= 1'b1;
    wr(8'h00, 32'h8082);
    meas(0, 8);
    ext_run <= 1'b0;
    $display("source test done");
    @(posedge CLK);
    DEV_IDLE <= 1'b1;
    wr(8'h00, 32'hA000);
    wr(8'h80, 32'hFF);
    repeat (20) @(negedge CLK);
    chk(MATCH_FLAGS[0], 32'h0);
    wr(8'h00, 32'h8000);
    meas(0, 4);
    @(posedge CLK);
    CE <= 1'b0;
    repeat (6) @(posedge CLK);
    CE <= 1'b1;
    DEV_IDLE <= 1'b0;
    $display("idle test done");
    wr(8'h00, 32'h0);
    wr(8'h08, 32'hFFFF);
    wr(8'h04, 32'hFFFE);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h1);
    wr(8'h10, 32'h70);
    wr(8'h00, 32'h8008);
    repeat (8) @(posedge CLK);
    wr(8'h00, 32'h0);
    rd(8'h14, 32'h1);
    $display("chain test done");
    conclude();
  end
endmodule
bind tbt_top tbt_asserts #(.NUM_TIMERS(NUM_TIMERS)) chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
  .CE(CE), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
  .RD_DATA(RD_DATA), .MATCH_FLAGS(MATCH_FLAGS));
